// ### testbench/wwdcm_assertions.sv
/*
  checker for wwdcm_top: bus timing, key read-back, pin drive and hold time.
  assumes only the ports of wwdcm_top; bound at the foot of this file.
*/
`timescale 1ns/1ps

module wwdcm_assertions #(
  parameter int CM_LIMIT_CYC = 50000
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        instr_cycle_en,
  input wire logic        halt_mode,
  input wire logic        idle_mode,
  input wire logic        port_g_bit1_pin_i,
  input wire logic        port_g_bit1_pin_o,
  input wire logic        port_g_bit1_pin_oe
);
  // ***********************************************************
  // ticks seen while the pin reads low and is driven
  // ***********************************************************
  logic [5:0] hold_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 6'h00;
    end else if (!port_g_bit1_pin_oe) begin
      hold_q <= 6'h00;
    end else if (!port_g_bit1_pin_i && instr_cycle_en && hold_q != 6'h3f) begin
      hold_q <= hold_q + 6'h01;
    end
  end

  // ***********************************************************
  // properties
  // ***********************************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence svc_wr;
    psel && penable && pready && pwrite && paddr == 12'h000;
  endsequence
  sequence bad_key;
    pwdata[5:1] != 5'h0c && !port_g_bit1_pin_oe && !halt_mode && !idle_mode;
  endsequence

  a_ready_wait: assert property (psel && $rose(penable) |=> pready)
    else $error("no answer one cycle after access");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held beyond one cycle");
  a_unmapped_err: assert property (pready |-> pslverr == (paddr != 12'h000 && paddr != 12'h004))
    else $error("error response wrong for address");
  a_key_reads_zero: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata[5:1] == 5'h00)
    else $error("key field not read as zero");
  a_reset_quiet: assert property (disable iff (1'b0) !presetn |-> !port_g_bit1_pin_oe)
    else $error("pin driven during reset");
  a_pin_low_drive: assert property (port_g_bit1_pin_oe |-> !port_g_bit1_pin_o)
    else $error("pin driven high");
  a_hold_span: assert property ($fell(port_g_bit1_pin_oe) |-> hold_q >= 6'h10 && hold_q <= 6'h20)
    else $error("pin released outside hold span");
  a_bad_key_trips: assert property (svc_wr ##0 bad_key |-> ##[1:2] port_g_bit1_pin_oe)
    else $error("wrong key did not raise error");
endmodule

bind wwdcm_top wwdcm_assertions #(.CM_LIMIT_CYC(CM_LIMIT_CYC)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .instr_cycle_en(instr_cycle_en), .halt_mode(halt_mode), .idle_mode(idle_mode),
  .port_g_bit1_pin_i(port_g_bit1_pin_i), .port_g_bit1_pin_o(port_g_bit1_pin_o),
  .port_g_bit1_pin_oe(port_g_bit1_pin_oe)
);

// ### testbench/wwdcm_rst_model.sv
/*
  system reset circuit on the timeout pin: wire with weak pull-up and a
  threshold detector that answers promptly or after a lag.
  assumes the pin enables of wwdcm_top and the bench clock.
*/
`timescale 1ns/1ps

module wwdcm_rst_model (
  input  wire logic pclk,
  input  wire logic slow,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  output logic      pin_i,
  output logic      rst_req_n
);
  logic       wire_lvl;
  logic [3:0] lag_q;

  assign wire_lvl  = pin_oe ? pin_o : 1'b1; // pull-up when released
  assign rst_req_n = pin_i;

  initial begin
    pin_i = 1'b1;
    lag_q = 4'h0;
  end

  // slow edge crosses the threshold only after a lag
  always @(posedge pclk) begin
    lag_q <= (wire_lvl == pin_i) ? 4'h0 : lag_q + 4'h1;
    if (wire_lvl != pin_i && (!slow || lag_q == 4'h7)) begin
      pin_i <= wire_lvl;
    end
  end
endmodule

// ### testbench/wwdcm_tb_top.sv
/*
  testbench for wwdcm_top: apb tasks, reset-circuit model, checker bound.
  assumes design files, checker and model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("FAIL %s expected %h seen %h", nm, exp, got); \
  end \
end

module wwdcm_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, er;
  logic        tick_on, ls_on, slow, halt_mode, idle_mode, boot_rom_entry;
  logic        instr_cycle_en, ls_clk_en, pready, pslverr, pin_i, pin_o, pin_oe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  div_q;
  logic [31:0] bad [3] = '{32'h00000059, 32'h00000018, 32'h0000001b};
  int          err_total, tests_run, cyc;

  wwdcm_top #(.CM_LIMIT_CYC(200)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_cycle_en(instr_cycle_en), .ls_clk_en(ls_clk_en), .halt_mode(halt_mode),
    .idle_mode(idle_mode), .boot_rom_entry(boot_rom_entry), .port_g_bit1_pin_i(pin_i),
    .port_g_bit1_pin_o(pin_o), .port_g_bit1_pin_oe(pin_oe)
  );
  wwdcm_rst_model u_rst (.pclk(pclk), .slow(slow), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i), .rst_req_n());

  // ***********************************************************
  // clock, tick enables, run limit
  // ***********************************************************
  always #10 pclk = ~pclk;

  always @(posedge pclk) begin
    div_q <= div_q + 3'h1;
    instr_cycle_en <= tick_on && div_q[0];
    ls_clk_en <= ls_on && div_q == 3'h0;
    cyc++;
    if (cyc == 95000) begin
      err_total++;
      stop_test();
    end
  end

  // ***********************************************************
  // tasks
  // ***********************************************************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    `CHK(nm, exp, rd)
  endtask

  // wait for the pin enable to reach v, or require it to stay at v
  task automatic see_oe(input logic v, input int max, input logic stay);
    int n;
    for (n = 0; n < max; n++) begin
      @(posedge pclk);
      if ((pin_oe === v) != stay) break;
    end
    `CHK("timeout pin", v, pin_oe)
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial begin
    {pclk, psel, penable, pwrite, halt_mode, idle_mode, boot_rom_entry, ls_on, slow} = '0;
    {instr_cycle_en, ls_clk_en, div_q, paddr, pwdata, presetn} = '0;
    tick_on = 1'b1;
    err_total = 0;
    tests_run = 0;
    cyc = 0;
    do_reset();
    rd_chk("service reset", 12'h000, 32'h000000c1);
    rd_chk("control reset", 12'h004, 32'h00000000);
    rd_chk("unmapped read", 12'h008, 32'h00000000);
    `CHK("unmapped error", 1'b1, er)
    apb(1'b1, 12'h000, 32'h00000001);
    see_oe(1'b1, 4, 1'b0);
    see_oe(1'b0, 300, 1'b0);
    rd_chk("service kept", 12'h000, 32'h000000c1);
    for (int w = 0; w < 4; w++) begin
      do_reset();
      apb(1'b1, 12'h000, {24'h0, w[1:0], 6'h19});
      rd_chk("window latched", 12'h000, {24'h0, w[1:0], 6'h01});
      rd_chk("locked", 12'h004, 32'h00000100);
      if (w < 2) begin
        repeat ((16384 << w) - 60) @(posedge pclk);
        see_oe(1'b0, 1, 1'b1);
        see_oe(1'b1, 100, 1'b0);
      end
    end
    do_reset();
    apb(1'b1, 12'h000, 32'h00000019);
    repeat (100) @(posedge pclk);
    apb(1'b1, 12'h000, 32'h00000019);
    see_oe(1'b1, 4, 1'b0);
    see_oe(1'b0, 300, 1'b0);
    repeat (4200) @(posedge pclk);
    apb(1'b1, 12'h000, 32'h00000019);
    see_oe(1'b0, 20, 1'b1);
    rd_chk("error cleared", 12'h004, 32'h00000100);
    foreach (bad[i]) begin
      repeat (4200) @(posedge pclk);
      apb(1'b1, 12'h000, bad[i]);
      see_oe(1'b1, 4, 1'b0);
      see_oe(1'b0, 300, 1'b0);
    end
    rd_chk("window locked", 12'h000, 32'h00000001);
    repeat (4200) @(posedge pclk);
    apb(1'b1, 12'h000, 32'h00000019);
    boot_rom_entry <= 1'b1;
    @(posedge pclk);
    boot_rom_entry <= 1'b0;
    repeat (50) @(posedge pclk);
    apb(1'b1, 12'h000, 32'h00000019);
    see_oe(1'b0, 20, 1'b1);
    slow <= 1'b1;
    apb(1'b1, 12'h000, 32'h00000019);
    see_oe(1'b1, 4, 1'b0);
    see_oe(1'b0, 300, 1'b0);
    slow <= 1'b0;
    repeat (20) @(posedge pclk);
    apb(1'b1, 12'h004, 32'h00000004);
    apb(1'b1, 12'h000, 32'h00000019);
    see_oe(1'b0, 20, 1'b1);
    do_reset();
    ls_on <= 1'b1;
    apb(1'b1, 12'h004, 32'h00000001);
    apb(1'b1, 12'h000, 32'h00000019);
    repeat (4200) @(posedge pclk);
    apb(1'b1, 12'h000, 32'h00000019);
    see_oe(1'b1, 4, 1'b0);
    see_oe(1'b0, 300, 1'b0);
    do_reset();
    halt_mode <= 1'b1;
    apb(1'b1, 12'h000, 32'h00000001);
    see_oe(1'b0, 20, 1'b1);
    tick_on <= 1'b0;
    see_oe(1'b1, 300, 1'b0);
    tick_on <= 1'b1;
    halt_mode <= 1'b0;
    see_oe(1'b0, 300, 1'b0);
    do_reset();
    apb(1'b1, 12'h000, 32'h00000018);
    tick_on <= 1'b0;
    see_oe(1'b0, 400, 1'b1);
    stop_test();
  end
endmodule

// ### verilog/wwdcm_clkmon.sv
/*
  clock monitor: flags a missing or too slow instruction-cycle clock.
  assumes tick is a one-cycle pulse per instruction cycle in the pclk domain.
*/
`timescale 1ns/1ps

module wwdcm_clkmon #(
  parameter int LIMIT_CYC = wwdcm_pkg::CM_LIMIT_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic enable,
  input  wire logic tick,
  output logic      fault_q
);

  // ***********************************************************
  // gap counter
  // ***********************************************************
  localparam int                 W   = $clog2(LIMIT_CYC + 1);
  localparam logic [W-1:0]       LIM = W'(LIMIT_CYC);

  logic [W-1:0] gap_q;

  // gap counts from reset, so a dead oscillator is caught too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= '0;
    end else if (!enable || tick) begin
      gap_q <= '0;
    end else if (gap_q != LIM) begin
      gap_q <= gap_q + W'(1);
    end
  end

  // limit lies far above a 5 kHz period, so such clocks never trip
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= 1'b0;
    end else if (!enable || tick) begin
      fault_q <= 1'b0;
    end else if (gap_q == LIM) begin
      fault_q <= 1'b1;
    end
  end

endmodule

// ### verilog/wwdcm_pkg.sv
/*
  constants, register map, field layout and state type of the windowed
  watchdog with clock monitor.
  assumes a 50 MHz pclk and a 32-bit APB register bus.
*/
package wwdcm_pkg;

  // ***********************************************************
  // bus and register map
  // ***********************************************************
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  localparam logic [11:0] ADDR_SERVICE  = 12'h000;
  localparam logic [11:0] ADDR_CTRL     = 12'h004;

  // ***********************************************************
  // service register fields
  // ***********************************************************
  localparam int          WIN_MSB       = 7;
  localparam int          WIN_LSB       = 6;
  localparam int          KEY_MSB       = 5;
  localparam int          KEY_LSB       = 1;
  localparam int          CM_BIT        = 0;
  localparam logic [4:0]  SERVICE_KEY   = 5'h0c;
  localparam logic [1:0]  WIN_RESET     = 2'h3;
  localparam logic        CM_RESET      = 1'b1;

  // ***********************************************************
  // control / status register fields
  // ***********************************************************
  localparam int          CTRL_LS_BIT   = 0;
  localparam int          CTRL_OPT_BIT  = 2;
  localparam int          STAT_LOCK_BIT = 8;
  localparam int          STAT_CMF_BIT  = 9;
  localparam int          STAT_DRV_BIT  = 10;
  localparam int          STAT_WE_BIT   = 11;
  localparam logic        LS_RESET      = 1'b0;
  localparam logic        OPT_RESET     = 1'b0;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int          CNT_W         = 17;
  localparam logic [16:0] LOWER_LIMIT   = 17'h00800;
  localparam logic [16:0] UPPER_BASE    = 17'h02000;
  localparam int          HOLD_W        = 5;
  localparam logic [4:0]  HOLD_TICKS    = 5'h10;
  localparam int          CLK_PERIOD_NS = 20;
  localparam int          CM_LIMIT_NS   = 1000000;
  localparam int          CM_LIMIT_CYC  = CM_LIMIT_NS / CLK_PERIOD_NS;

  // ***********************************************************
  // pin sequencer states
  // ***********************************************************
  typedef enum logic [1:0] {
    PIN_IDLE,
    PIN_DRIVE,
    PIN_HOLD,
    PIN_WAIT_HIGH
  } wwdcm_pin_st_t;

endpackage

// ### verilog/wwdcm_top.sv
/*
  windowed watchdog with clock monitor, APB slave, active-low timeout pin.
  assumes instr_cycle_en and ls_clk_en are one-cycle enables in the pclk
  domain and the pin pad adds a weak pull-up when pin_oe is low.
*/
// Local design decisions: the register offsets and the APB register port.
//
// Contract
// - watchdog works only while option bit 2 is 0; pin becomes its output
// - all window timing is counted in the selected tick: instruction cycles or 32 kHz clocks
// - service byte: window select 7..6, key 5..1, monitor enable 0
// - a service is valid only with key 01100 in bits 5..1
// - service earlier than 2048 clocks after previous one is an error
// - window select 00/01/10/11 gives upper limit 8k/16k/32k/64k
// - high speed counts instruction cycles, other modes the 32 kHz clock
// - service bit 0 disables or enables the clock monitor
// - detectors off in reset; afterwards max window and monitor enabled
// - after reset a slow or dead instruction clock is a monitor error
// - monitor never trips at instruction clocks of 5 kHz or more
// - first key-matching write locks window select and monitor enable
// - later writes must match all fields, otherwise an error
// - missing the upper limit or servicing twice too soon is an error
// - boot rom entry suppresses lower error and services at once
// - error pulls pin low, held 16 to 32 cycles after it reads low
// - a fully matching service inside the window restarts the window
// - service writes are ignored while the pin is driven low
// - key field reads back as zeros
// - watchdog stops in halt and idle, clock monitor keeps running
`timescale 1ns/1ps

module wwdcm_top #(
  parameter int CM_LIMIT_CYC = wwdcm_pkg::CM_LIMIT_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        instr_cycle_en,
  input  wire logic        ls_clk_en,
  input  wire logic        halt_mode,
  input  wire logic        idle_mode,
  input  wire logic        boot_rom_entry,
  input  wire logic        port_g_bit1_pin_i,
  output logic             port_g_bit1_pin_o,
  output logic             port_g_bit1_pin_oe
);

  // ***********************************************************
  // declarations
  // ***********************************************************
  logic [1:0]               win_sel_q;
  logic                     cm_en_q;
  logic                     locked_q;
  logic                     low_speed_q;
  logic                     option_q;
  logic                     lower_off_q;
  logic                     idle_q;
  logic                     wd_err_q;
  logic [wwdcm_pkg::CNT_W-1:0]  cnt_q;
  logic [wwdcm_pkg::HOLD_W-1:0] hold_q;
  wwdcm_pkg::wwdcm_pin_st_t pin_st_q;
  logic                     pready_q;
  logic                     pslverr_q;
  logic [31:0]              prdata_q;
  logic                     pin_oe_q;
  logic                     cm_fault;

  logic                     wd_on;
  logic                     tick;
  logic                     acc;
  logic                     wr_svc;
  logic                     wr_ctrl;
  logic                     hit;
  logic                     driving;
  logic                     key_ok;
  logic                     all_ok;
  logic                     lower_ok;
  logic [wwdcm_pkg::CNT_W-1:0] upper;
  logic                     timeout;
  logic                     svc_good;
  logic                     svc_bad;
  logic                     hw_service;
  logic                     restart;

  // ***********************************************************
  // common terms
  // ***********************************************************
  assign wd_on    = !option_q && !halt_mode && !idle_mode;
  assign tick     = low_speed_q ? ls_clk_en : instr_cycle_en;
  assign acc      = psel && penable && pready_q;
  assign hit      = (paddr == wwdcm_pkg::ADDR_SERVICE) || (paddr == wwdcm_pkg::ADDR_CTRL);
  assign wr_svc   = acc && pwrite && (paddr == wwdcm_pkg::ADDR_SERVICE);
  assign wr_ctrl  = acc && pwrite && (paddr == wwdcm_pkg::ADDR_CTRL);
  assign driving  = pin_st_q != wwdcm_pkg::PIN_IDLE;
  assign key_ok   = pwdata[wwdcm_pkg::KEY_MSB:wwdcm_pkg::KEY_LSB] == wwdcm_pkg::SERVICE_KEY;
  assign all_ok   = key_ok
                    && (pwdata[wwdcm_pkg::WIN_MSB:wwdcm_pkg::WIN_LSB] == win_sel_q)
                    && (pwdata[wwdcm_pkg::CM_BIT] == cm_en_q);
  assign lower_ok = lower_off_q || (cnt_q >= wwdcm_pkg::LOWER_LIMIT);
  assign upper    = wwdcm_pkg::UPPER_BASE << win_sel_q;
  assign timeout  = wd_on && !driving && (cnt_q >= upper);

  // a write only counts as a service while the pin sequencer is idle
  always_comb begin
    svc_good = 1'b0;
    svc_bad  = 1'b0;
    if (wr_svc && wd_on && !driving) begin
      if (!locked_q) begin
        svc_good = key_ok;
        svc_bad  = !key_ok;
      end else begin
        svc_good = all_ok && lower_ok;
        svc_bad  = !(all_ok && lower_ok);
      end
    end
  end

  // idle exit and boot rom entry service the watchdog in hardware
  assign hw_service = (boot_rom_entry || (idle_q && !idle_mode)) && !driving;
  assign restart    = svc_good || hw_service
                      || (pin_st_q == wwdcm_pkg::PIN_WAIT_HIGH && port_g_bit1_pin_i);

  // ***********************************************************
  // service register
  // ***********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_sel_q <= wwdcm_pkg::WIN_RESET;
      cm_en_q   <= wwdcm_pkg::CM_RESET;
      locked_q  <= 1'b0;
    end else if (svc_good && !locked_q) begin
      win_sel_q <= pwdata[wwdcm_pkg::WIN_MSB:wwdcm_pkg::WIN_LSB];
      cm_en_q   <= pwdata[wwdcm_pkg::CM_BIT];
      locked_q  <= 1'b1;
    end
  end

  // ***********************************************************
  // control register
  // ***********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_speed_q <= wwdcm_pkg::LS_RESET;
      option_q    <= wwdcm_pkg::OPT_RESET;
    end else if (wr_ctrl) begin
      low_speed_q <= pwdata[wwdcm_pkg::CTRL_LS_BIT];
      option_q    <= pwdata[wwdcm_pkg::CTRL_OPT_BIT];
    end
  end

  // ***********************************************************
  // window counter
  // ***********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (restart) begin
      cnt_q <= '0;
    end else if (wd_on && tick && !driving && cnt_q < upper) begin
      cnt_q <= cnt_q + wwdcm_pkg::CNT_W'(1);
    end
  end

  // lower check stays off from boot entry until the next good service
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lower_off_q <= 1'b0;
    end else if (boot_rom_entry) begin
      lower_off_q <= 1'b1;
    end else if (svc_good) begin
      lower_off_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_q <= 1'b0;
    end else begin
      idle_q <= idle_mode;
    end
  end

  // sticky record of the last watchdog error, cleared on a good service
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_err_q <= 1'b0;
    end else if (svc_bad || timeout) begin
      wd_err_q <= 1'b1;
    end else if (svc_good) begin
      wd_err_q <= 1'b0;
    end
  end

  // ***********************************************************
  // clock monitor
  // ***********************************************************
  wwdcm_clkmon #(
    .LIMIT_CYC (CM_LIMIT_CYC)
  ) u_clkmon (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (cm_en_q && !option_q),
    .tick    (instr_cycle_en),
    .fault_q (cm_fault)
  );

  // ***********************************************************
  // timeout pin sequencer
  // ***********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_st_q <= wwdcm_pkg::PIN_IDLE;
      hold_q   <= '0;
    end else begin
      case (pin_st_q)
        wwdcm_pkg::PIN_IDLE: begin
          if (svc_bad || timeout || cm_fault) begin
            pin_st_q <= wwdcm_pkg::PIN_DRIVE;
          end
        end
        wwdcm_pkg::PIN_DRIVE: begin
          hold_q <= '0;
          if (!port_g_bit1_pin_i && !cm_fault) begin
            pin_st_q <= wwdcm_pkg::PIN_HOLD;
          end
        end
        wwdcm_pkg::PIN_HOLD: begin
          if (cm_fault) begin
            pin_st_q <= wwdcm_pkg::PIN_DRIVE;
          end else if (hold_q == wwdcm_pkg::HOLD_TICKS) begin
            pin_st_q <= wwdcm_pkg::PIN_WAIT_HIGH;
          end else if (instr_cycle_en) begin
            hold_q <= hold_q + wwdcm_pkg::HOLD_W'(1);
          end
        end
        wwdcm_pkg::PIN_WAIT_HIGH: begin
          if (cm_fault) begin
            pin_st_q <= wwdcm_pkg::PIN_DRIVE;
          end else if (port_g_bit1_pin_i) begin
            pin_st_q <= wwdcm_pkg::PIN_IDLE;
          end
        end
        default: begin
          pin_st_q <= wwdcm_pkg::PIN_IDLE;
        end
      endcase
    end
  end

  // pin driven low in drive and hold, released to the pull-up otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_oe_q <= 1'b0;
    end else begin
      case (pin_st_q)
        wwdcm_pkg::PIN_IDLE:  pin_oe_q <= svc_bad || timeout || cm_fault;
        wwdcm_pkg::PIN_DRIVE: pin_oe_q <= 1'b1;
        wwdcm_pkg::PIN_HOLD:  pin_oe_q <= cm_fault || (hold_q != wwdcm_pkg::HOLD_TICKS);
        default:   pin_oe_q <= cm_fault;
      endcase
    end
  end

  assign port_g_bit1_pin_o  = 1'b0;
  assign port_g_bit1_pin_oe = pin_oe_q;

  // ***********************************************************
  // apb slave
  // ***********************************************************
  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (psel && penable && !pready_q && !pwrite) begin
      prdata_q <= '0;
      if (paddr == wwdcm_pkg::ADDR_SERVICE) begin
        prdata_q[wwdcm_pkg::WIN_MSB:wwdcm_pkg::WIN_LSB] <= win_sel_q;
        prdata_q[wwdcm_pkg::CM_BIT]                     <= cm_en_q;
      end else if (paddr == wwdcm_pkg::ADDR_CTRL) begin
        prdata_q[wwdcm_pkg::CTRL_LS_BIT]   <= low_speed_q;
        prdata_q[wwdcm_pkg::CTRL_OPT_BIT]  <= option_q;
        prdata_q[wwdcm_pkg::STAT_LOCK_BIT] <= locked_q;
        prdata_q[wwdcm_pkg::STAT_CMF_BIT]  <= cm_fault;
        prdata_q[wwdcm_pkg::STAT_DRV_BIT]  <= driving;
        prdata_q[wwdcm_pkg::STAT_WE_BIT]   <= wd_err_q;
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

endmodule

// ### verilog/zz_unused.sv
`timescale 1ns/1ps
